// [tb/call_progress_output_load_model.sv]
/*
  Load on the call progress output: a filter seen as a count of high cycles.
  Assumes the pin is sampled on clk_in and that the bench clears the count.
*/
`timescale 1ns/1ps
`default_nettype none
module call_progress_output_load_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic pin_in,
  input wire logic clear_in,
  output logic [15:0] ones_out
);
  // Averaging stands in for the filter, so pulse jitter of one cycle is harmless
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ones_out <= 16'h0000;
    end else if (clear_in) begin
      ones_out <= 16'h0000;
    end else begin
      ones_out <= ones_out + {15'h0000, pin_in};
    end
  end
endmodule
`default_nettype wire

// [tb/call_progress_pwm_control_test.sv]
/*
  Self-checking bench for the control register and call progress modulator.
  Assumes the Avalon slave answers by waitrequest and the load model above.
*/
`timescale 1ns/1ps
`default_nettype none
module call_progress_pwm_control_test;
  import cp_pwm_pkg::*;
  logic clk_in, reset_n_in, rd, wr, wait_req, isel, ilevel, lb_out, sr_pulse, pin, clr;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, r;
  logic [3:0] be;
  logic signed [15:0] tx, rx, brx, rx_audio;
  logic [15:0] ones;
  int mismatches, samples_checked, cycles, pulses;

  call_progress_pwm_control dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .tx_sample_in(tx), .rx_sample_in(rx),
    .barrier_rx_in(brx), .irq_pin_select_in(isel), .irq_level_in(ilevel), .rx_audio_out(rx_audio),
    .barrier_loopback_enable_out(lb_out), .soft_reset_pulse_out(sr_pulse),
    .shared_monitor_irq_pin_out(pin));
  call_progress_output_load_model load_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .pin_in(pin), .clear_in(clr),
    .ones_out(ones));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: the full run needs about 80000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Pulses are counted at the falling edge, where the registered output is settled
  always @(negedge clk_in) begin
    if (sr_pulse === 1'b1) begin
      pulses++;
    end
  end

  // Waitrequest is sampled at each rising edge; the edge that sees it low takes the transfer
  task automatic wait_ack;
    @(posedge clk_in);
    while (wait_req !== 1'b0) begin
      @(posedge clk_in);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] e);
    @(posedge clk_in);
    addr <= a;
    wdata <= {24'h00_0000, d};
    be <= e;
    wr <= 1'b1;
    wait_ack();
    wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    wait_ack();
    d = rdata;
    rd <= 1'b0;
  endtask

  // Expected high cycles in a 6250-cycle window for a summed level s
  function automatic int exp_ones(input logic [1:0] m, input int s);
    int off;
    off = s + 32768;
    case (m)
      2'b00: exp_ones = off * 6250 / 65536;
      2'b01: exp_ones = (off / 256) * 6250 / 256;
      2'b10: exp_ones = (255 - off / 256) * 6250 / 256;
      default: exp_ones = 0;
    endcase
  endfunction

  // One settle period, then a window; the filter tolerates rate jitter, hence the margin
  task automatic density(input logic [7:0] c, input int s, input int exp);
    int n;
    tx <= 16'(s / 2);
    rx <= 16'(s / 2);
    bus_write(CTRL1_ADDR, c, 4'hF);
    repeat (1600) @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    repeat (6250) @(posedge clk_in);
    @(negedge clk_in);
    n = int'(ones) - exp;
    check({31'h0000_0000, (n < 400 && n > -400)}, 32'h0000_0001);
  endtask

  initial begin
    {rd, wr, isel, ilevel, clr, addr, wdata, tx, rx, brx} = '0;
    be = 4'hF;
    cycles = 0;
    pulses = 0;
    mismatches = 0;
    samples_checked = 0;
    reset_n_in = 1'b0;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    bus_read(CTRL1_ADDR, r);
    check(r, {24'h00_0000, CTRL1_RESET});
    // Bit seven stays clear here, or the write would be a soft reset
    bus_write(CTRL1_ADDR, 8'h7F, 4'hF); // line side taken as enabled and off-hook
    bus_read(CTRL1_ADDR, r);
    check(r, 32'h0000_003A);
    tx <= 16'h1234;
    brx <= 16'h5678;
    repeat (2) @(posedge clk_in);
    check({31'h0000_0000, lb_out}, 32'h0000_0001);
    check({16'h0000, rx_audio}, 32'h0000_1234);
    // Unmapped place and a write without its byte lane both leave the register alone
    bus_write(8'h08, 8'h00, 4'hF);
    bus_read(8'h08, r);
    check(r, 32'h0000_0000);
    bus_write(CTRL1_ADDR, 8'h00, 4'hE);
    bus_read(CTRL1_ADDR, r);
    check(r, 32'h0000_003A);
    bus_write(CTRL1_ADDR, 8'h00, 4'hF);
    repeat (2) @(posedge clk_in);
    check({16'h0000, rx_audio}, 32'h0000_5678);
    bus_write(CTRL1_ADDR, 8'hBA, 4'hF);
    repeat (4) @(posedge clk_in);
    check(32'(pulses), 32'h0000_0001);
    bus_read(CTRL1_ADDR, r);
    check(r, 32'h0000_0000);
    for (int m = 0; m < 3; m++) begin
      density(8'(m * 16 + 8), 24576, exp_ones(2'(m), 24576));
      density(8'(m * 16 + 8), -24576, exp_ones(2'(m), -24576));
    end
    density(8'h38, 24576, 0);
    density(8'h10, 24576, 0);
    isel <= 1'b1;
    ilevel <= 1'b1;
    // Saturated low sum gives a silent stream, so a leak of the modulator would show
    density(8'h08, -65536, 6250);
    ilevel <= 1'b0;
    density(8'h18, 24576, 0);
    give_verdict();
  end
endmodule
`default_nettype wire

// [verilog/call_progress_pwm_control.sv]
/*
  Control register one and the call progress output modulator it configures.
  Assumes an Avalon-MM master on clk_in and audio samples from logic on clk_in.
*/
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
module call_progress_pwm_control
  import cp_pwm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic signed [15:0] tx_sample_in,
  input wire logic signed [15:0] rx_sample_in,
  input wire logic signed [15:0] barrier_rx_in,
  input wire logic irq_pin_select_in,
  input wire logic irq_level_in,
  output logic signed [15:0] rx_audio_out,
  output logic barrier_loopback_enable_out,
  output logic soft_reset_pulse_out,
  output logic shared_monitor_irq_pin_out
);
  ctrl_one_t ctrl_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic ds_tick;
  logic fine_tick;
  logic [16:0] ds_acc_reg;
  logic [8:0] pos_reg;
  logic [7:0] duty16_reg;
  logic [7:0] duty32_reg;
  logic call_progress_output_reg;
  logic pin_reg;
  logic signed [15:0] rx_audio_reg;

  // Bus decode; every request is answered on its second cycle
  wire req = avs_read_in | avs_write_in;
  wire hit = avs_address_in == CTRL1_ADDR;
  wire write_fire = avs_write_in & ack_reg & hit & avs_byteenable_in[0];
  wire sr_write = write_fire & avs_writedata_in[SR_BIT];
  wire [7:0] ctrl_rd = 8'(ctrl_reg) & ~CTRL1_RSV_MASK & ~(8'h80);
  assign avs_waitrequest_out = req & ~ack_reg;
  assign avs_readdata_out = readdata_reg;

  // Bus handshake and read data capture in the first cycle of a request
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read_in & ~ack_reg) begin
        readdata_reg <= hit ? {24'h00_0000, ctrl_rd} : 32'h0000_0000;
      end
    end
  end

  // Control register; a soft reset write wins over the other fields
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= ctrl_one_t'(CTRL1_RESET);
      soft_reset_pulse_out <= 1'b0;
    end else if (sr_write) begin
      ctrl_reg <= ctrl_one_t'(CTRL1_RESET);
      soft_reset_pulse_out <= 1'b1;
    end else begin
      soft_reset_pulse_out <= 1'b0;
      if (write_fire) begin
        ctrl_reg <= ctrl_one_t'(avs_writedata_in[7:0] & ~CTRL1_RSV_MASK & ~(8'h80));
      end
    end
  end

  // Rate enables; the dividers, accumulator, position counter and duty latches restart with a soft reset
  frac_tick #(.INC(DS_INC), .MOD(SYS_MOD)) u_ds_tick (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clear_in(soft_reset_pulse_out),
    .tick_out(ds_tick)
  );
  frac_tick #(.INC(FINE_INC), .MOD(SYS_MOD)) u_fine_tick (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clear_in(soft_reset_pulse_out),
    .tick_out(fine_tick)
  );

  // Summed audio, saturated, then offset binary so zero sits at mid-scale
  wire signed [16:0] sum_wide = 17'(tx_sample_in) + 17'(rx_sample_in);
  wire sat_hi = (sum_wide[16:15] == 2'b01);
  wire sat_lo = (sum_wide[16:15] == 2'b10);
  wire [15:0] sum_sat = sat_hi ? 16'h7FFF : (sat_lo ? 16'h8000 : sum_wide[15:0]);
  wire [15:0] level_u = {~sum_sat[15], sum_sat[14:0]};
  wire [7:0] duty_now = level_u[15:8];

  // Period markers; 512 fine steps per 16 kHz period, 256 per 32 kHz period
  wire start16 = fine_tick & (pos_reg == POS_LAST);
  wire start32 = fine_tick & (pos_reg[7:0] == HALF_LAST);
  wire [8:0] win_lo = POS_MID - {1'b0, duty16_reg};
  wire [8:0] win_hi = POS_MID + {1'b0, duty16_reg};
  wire ds_bit = ds_acc_reg[16];
  wire pwm_centred = (pos_reg >= win_lo) && (pos_reg < win_hi);
  wire pwm_trailing = pos_reg[7:0] > duty32_reg;
  wire mod_bit = (ctrl_reg.sel == MOD_DELTA_SIGMA) ? ds_bit :
                 (ctrl_reg.sel == MOD_CENTRED_PWM) ? pwm_centred :
                 (ctrl_reg.sel == MOD_TRAILING_PWM) ? pwm_trailing : 1'b0;
  wire call_progress_output_next = ctrl_reg.en & mod_bit;

  // First-order delta-sigma: the carry out is the stream bit
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ds_acc_reg <= 17'h0_0000;
    end else if (soft_reset_pulse_out) begin
      ds_acc_reg <= 17'h0_0000;
    end else if (ds_tick) begin
      ds_acc_reg <= {1'b0, ds_acc_reg[15:0]} + {1'b0, level_u};
    end
  end

  // Fine position counter and duty latches taken at each period start
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pos_reg <= 9'h000;
      duty16_reg <= 8'h00;
      duty32_reg <= 8'h00;
    end else if (soft_reset_pulse_out) begin
      pos_reg <= 9'h000;
      duty16_reg <= 8'h00;
      duty32_reg <= 8'h00;
    end else if (fine_tick) begin
      pos_reg <= pos_reg + 9'h001;
      if (start16) begin
        duty16_reg <= duty_now;
      end
      if (start32) begin
        duty32_reg <= duty_now;
      end
    end
  end

  // Output stage: shared pin carries audio only in monitor mode
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      call_progress_output_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else begin
      call_progress_output_reg <= call_progress_output_next;
      pin_reg <= irq_pin_select_in ? irq_level_in : call_progress_output_reg;
    end
  end
  assign shared_monitor_irq_pin_out = pin_reg;

  // Loopback returns transmit audio on the receive path; the host must
  // have the line side off-hook first, which this block cannot check
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_audio_reg <= 16'sh0000;
    end else begin
      rx_audio_reg <= ctrl_reg.lb ? tx_sample_in : barrier_rx_in;
    end
  end
  assign rx_audio_out = rx_audio_reg;
  assign barrier_loopback_enable_out = ctrl_reg.lb;

  // Checks
  sequence s_sr_write;
    sr_write;
  endsequence
  sequence s_sr_pulse;
    soft_reset_pulse_out ##1 !soft_reset_pulse_out;
  endsequence

  property p_sr_self_clear;
    @(posedge clk_in) disable iff (!reset_n_in) s_sr_write |=> s_sr_pulse;
  endproperty
  a_sr_self_clear: assert property (p_sr_self_clear) else $error("soft reset did not clear itself");

  property p_sr_resets;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_sr_write |=> (8'(ctrl_reg) == CTRL1_RESET) ##1 (ds_acc_reg == 17'h0_0000);
  endproperty
  a_sr_resets: assert property (p_sr_resets) else $error("soft reset left state set");

  property p_reserved_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      (avs_read_in && !avs_waitrequest_out) |-> ((avs_readdata_out[7:0] & (CTRL1_RSV_MASK | 8'h80)) == 8'h00);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved or soft reset bit read as one");

  property p_disabled_low;
    @(posedge clk_in) disable iff (!reset_n_in) !ctrl_reg.en |=> !call_progress_output_reg;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("output active while disabled");

  property p_reserved_mode;
    @(posedge clk_in) disable iff (!reset_n_in) (ctrl_reg.sel == MOD_RESERVED) |=> !call_progress_output_reg;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode) else $error("reserved mode drove output");

  property p_pin_share;
    @(posedge clk_in) disable iff (!reset_n_in)
      !irq_pin_select_in |=> (shared_monitor_irq_pin_out == $past(call_progress_output_reg));
  endproperty
  a_pin_share: assert property (p_pin_share) else $error("monitor audio missing on shared pin");

  property p_loopback;
    @(posedge clk_in) disable iff (!reset_n_in) ctrl_reg.lb |=> (rx_audio_out == $past(tx_sample_in));
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback data mismatch");

  property p_ds_zero_input;
    @(posedge clk_in) disable iff (!reset_n_in)
      (ds_tick && !soft_reset_pulse_out && level_u == 16'h0000) |=> !ds_acc_reg[16];
  endproperty
  a_ds_zero_input: assert property (p_ds_zero_input) else $error("delta-sigma carry without input");

  property p_trailing_fall;
    @(posedge clk_in) disable iff (!reset_n_in)
      (start32 && !write_fire && !soft_reset_pulse_out && ctrl_reg.en && ctrl_reg.sel == MOD_TRAILING_PWM)
      |=> !write_fire ##1 !call_progress_output_reg;
  endproperty
  a_trailing_fall: assert property (p_trailing_fall) else $error("output not low at 32 kHz boundary");

  property p_centred_mid;
    @(posedge clk_in) disable iff (!reset_n_in)
      (pos_reg == POS_MID && duty16_reg != 8'h00 && ctrl_reg.en && ctrl_reg.sel == MOD_CENTRED_PWM)
      |=> call_progress_output_reg;
  endproperty
  a_centred_mid: assert property (p_centred_mid) else $error("centred pulse missing mid-period");
endmodule
`default_nettype wire

// [verilog/cp_pwm_pkg.sv]
/*
  Shared constants and types for the call progress modulator control block.
  Assumes a 25 MHz system clock and 16-bit signed audio samples on that clock.
*/
`default_nettype none
package cp_pwm_pkg;
  // Register index as printed; byte address is four times the index
  localparam logic [7:0] CTRL1_IDX = 8'h01;
  localparam logic [7:0] CTRL1_ADDR = 8'h04;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RSV_MASK = 8'h45;
  // Field positions
  localparam int SR_BIT = 7;
  localparam int SEL_LSB = 4;
  localparam int EN_BIT = 3;
  localparam int LB_BIT = 1;
  // Rates in kHz as printed, and the system clock rate
  localparam int SYS_KHZ = 25000;
  localparam int DS_KHZ = 16384;
  localparam int SAMPLE_KHZ = 16;
  localparam int FINE_STEPS = 512;
  localparam int FINE_KHZ = SAMPLE_KHZ * FINE_STEPS;
  localparam logic [15:0] SYS_MOD = 16'(SYS_KHZ);
  localparam logic [15:0] DS_INC = 16'(DS_KHZ);
  localparam logic [15:0] FINE_INC = 16'(FINE_KHZ);
  localparam logic [8:0] POS_MID = 9'h100;
  localparam logic [8:0] POS_LAST = 9'h1FF;
  localparam logic [7:0] HALF_LAST = 8'hFF;

  typedef enum logic [1:0] {
    MOD_DELTA_SIGMA = 2'b00,
    MOD_CENTRED_PWM = 2'b01,
    MOD_TRAILING_PWM = 2'b10,
    MOD_RESERVED = 2'b11
  } mod_sel_t;

  typedef struct packed {
    logic soft_reset;
    logic rsv6;
    mod_sel_t sel;
    logic en;
    logic rsv2;
    logic lb;
    logic rsv0;
  } ctrl_one_t;
endpackage
`default_nettype wire

// [verilog/frac_tick.sv]
/*
  Fractional rate divider: emits a one-cycle enable at INC/MOD of the clock rate.
  Assumes INC is below MOD and both fit in 16 bits with their sum.
*/
`timescale 1ns/1ps
`default_nettype none
module frac_tick #(
  parameter logic [15:0] INC = 16'h0001,
  parameter logic [15:0] MOD = 16'h0002
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clear_in,
  output logic tick_out
);
  logic [15:0] acc_reg;
  wire [15:0] sum = acc_reg + INC;
  wire wrap = sum >= MOD;

  // Phase accumulator; average rate is exact, jitter is one clock
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_reg <= 16'h0000;
      tick_out <= 1'b0;
    end else if (clear_in) begin
      acc_reg <= 16'h0000;
      tick_out <= 1'b0;
    end else begin
      acc_reg <= wrap ? sum - MOD : sum;
      tick_out <= wrap;
    end
  end
endmodule
`default_nettype wire
